// File: design/spi_pkg.sv
// Shared constants and carrier types of the SPI master/slave controller
package spi_pkg;

   // ****************************************
   // Sizes and limits
   // ****************************************
   localparam int DATA_W   = 16;
   localparam int BITS_W   = 5;
   localparam int DIV_W    = 8;
   localparam int EDGE_W   = 6;
   localparam int SYNC_W   = 5;

   localparam logic [BITS_W-1:0] MIN_BITS = 5'h08;
   localparam logic [BITS_W-1:0] MAX_BITS = 5'h10;
   // Smallest allowed divide ratio: SCK at most one eighth of clk
   localparam logic [DIV_W-1:0]  MIN_DIV  = 8'h08;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic              master;
      logic              cpol;
      logic              cpha;
      logic [BITS_W-1:0] bits;
   } cfg_t;

   typedef struct packed {
      logic slave_abort_flag;
      logic mode_fault_flag;
      logic read_overrun_flag;
      logic write_collision_flag;
      logic transfer_done_flag;
   } status_t;

   localparam status_t STATUS_RST = 5'h00;

   typedef enum logic {M_IDLE, M_RUN} mst_state_t;

endpackage : spi_pkg

// File: design/spi_sync.sv
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module spi_sync
#(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= INIT;
         q_o  <= INIT;
      end
      else if (ce_i)
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule : spi_sync
`default_nettype wire

// File: design/spi_slave_link.sv
// Slave shifter running on the external master's SCK
`timescale 1ns/1ps
`default_nettype none
module spi_slave_link
(
   input  wire logic                         sck_i,
   input  wire logic                         sys_rst_i,
   input  wire logic                         sel_rst_i,
   input  wire logic                         cpol_i,
   input  wire logic                         cpha_i,
   input  wire logic [spi_pkg::BITS_W-1:0]   bits_i,
   input  wire logic [spi_pkg::DATA_W-1:0]   tx_i,
   input  wire logic                         mosi_i,
   output logic                              miso_o,
   output logic                              mid_o,
   output logic                              done_tgl_o,
   output logic      [spi_pkg::DATA_W-1:0]   rx_o
);
   import spi_pkg::*;

   logic [BITS_W-1:0] pcnt;
   logic [BITS_W-1:0] ncnt;
   logic [DATA_W-1:0] rx_sh;

   // Rising edge of lclk is always the sampling edge
   wire               lclk    = sck_i ^ (cpol_i ^ cpha_i);
   wire               last    = (pcnt == bits_i - 5'h01);
   wire [DATA_W-1:0]  rx_next = {rx_sh[DATA_W-2:0], mosi_i};
   wire [BITS_W-1:0]  nidx    = cpha_i ? ((ncnt == 5'h00) ? 5'h00
                                                        : ncnt - 5'h01)
                                     : ((ncnt >= bits_i) ? 5'h00 : ncnt);
   wire [BITS_W-1:0]  tx_idx  = bits_i - 5'h01 - nidx;

   // ****************************************
   // Sampling side
   // ****************************************
   always_ff @(posedge lclk or posedge sel_rst_i)
   begin
      if (sel_rst_i)
      begin
         pcnt  <= 5'h00;                                     // RULE_01
         rx_sh <= DATA_RST;                                  // RULE_17
      end
      else
      begin
         pcnt  <= last ? 5'h00 : pcnt + 5'h01;               // RULE_02
         rx_sh <= rx_next;
      end
   end

   // Word end: toggle survives deselect, so only system reset clears it
   always_ff @(posedge lclk or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         done_tgl_o <= 1'b0;
         rx_o       <= DATA_RST;
      end
      else if (last)
      begin
         done_tgl_o <= ~done_tgl_o;                          // RULE_10
         rx_o       <= rx_next;
      end
   end

   // ****************************************
   // Driving side
   // ****************************************
   always_ff @(negedge lclk or posedge sel_rst_i)
   begin
      if (sel_rst_i)
         ncnt <= 5'h00;
      else
         ncnt <= (ncnt == bits_i) ? 5'h01 : ncnt + 5'h01;   // RULE_20
   end

   assign miso_o = tx_i[tx_idx[3:0]];                        // RULE_20
   assign mid_o  = (pcnt != 5'h00);

endmodule : spi_slave_link
`default_nettype wire

// File: design/spi_ctrl.sv
// SPI master/slave controller with single data register and status flags
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// RULE_01 - Slave, phase 0: transfer spans the time slave select is active.
// RULE_02 - Slave, phase 1: first SCK edge to last sampling edge.
// RULE_03 - Status is read-only: done, overrun, collision, fault, abort.
// RULE_04 - No transmit buffer; data write loads the shift register.
// RULE_05 - Completed data goes to a receive buffer; data reads return it.
// RULE_06 - Clock counter sets SCK only in master mode.
// RULE_07 - Push-pull outputs; slave drives only while selected.
// RULE_08 - Master: data write starts a transfer and generates SCK.
// RULE_09 - Master: done flag set after the final SCK cycle.
// RULE_10 - Slave: done flag set after the last sampling edge.
// RULE_11 - Done clears on data access after a status read saw it set.
// RULE_12 - External master keeps SCK at most an eighth of clk.
// RULE_13 - Completion while done is set drops data, sets overrun.
// RULE_14 - Write inside the busy window is dropped, sets collision.
// RULE_15 - Software writes data in slave mode only between transfers.
// RULE_16 - Select while master: mode fault, drivers off, become slave.
// RULE_17 - Deselect mid-transfer drops data and sets slave abort.
// RULE_18 - Software sets control before a transfer and keeps it.
// RULE_19 - Master sequence: divider, control, write, wait, status, read.
// RULE_20 - Polarity and phase pick sample and drive edges.
// RULE_21 - Phase 0 master deselects between words; phase 1 may not.
// RULE_22 - Select is active low; abort leaves only the abort flag.
// RULE_23 - 8 to 16 bits per word; SCK at most an eighth of clk.
// RULE_24 - Master SCK is clk divided by the counter, at least eight.
// RULE_25 - Exception flags hold until a status read, then clear.
module spi_ctrl
(
   input  wire logic                        clk_i,
   input  wire logic                        sys_rst_i,
   input  wire logic                        ce_i,
   input  wire spi_pkg::cfg_t               cfg_i,
   input  wire logic [spi_pkg::DIV_W-1:0]   ccr_i,
   input  wire logic                        dat_wr_i,
   input  wire logic [spi_pkg::DATA_W-1:0]  dat_wdata_i,
   input  wire logic                        dat_rd_i,
   input  wire logic                        stat_rd_i,
   output logic      [spi_pkg::DATA_W-1:0]  rdata_o,
   output spi_pkg::status_t                 status_o,
   output logic                             master_o,
   input  wire logic                        spi_sck_i,
   output logic                             sck_o,
   output logic                             sck_oe_o,
   input  wire logic                        ssel_n_i,
   input  wire logic                        mosi_i,
   output logic                             mosi_o,
   output logic                             mosi_oe_o,
   input  wire logic                        miso_i,
   output logic                             miso_o,
   output logic                             miso_oe_o
);
   import spi_pkg::*;

   // ****************************************
   // State
   // ****************************************
   mst_state_t        state;
   mst_state_t        next_state;
   logic [DATA_W-1:0] shreg;
   logic [DATA_W-1:0] rx_buf;
   logic [DIV_W-2:0]  div_cnt;
   logic [EDGE_W-1:0] edge_cnt;
   logic              m_done;
   logic              fault_lock;
   logic              armed;
   logic              wc_window;
   logic              slv_open;
   logic              ssel_prev;
   logic              tgl_prev;
   status_t           flags;

   // ****************************************
   // Link side and synchronisers
   // ****************************************
   logic              link_miso;
   logic              link_mid;
   logic              link_tgl;
   logic [DATA_W-1:0] link_rx;
   logic [SYNC_W-1:0] sync_q;

   wire  [BITS_W-1:0] nb = (cfg_i.bits < MIN_BITS) ? MIN_BITS :
                           (cfg_i.bits > MAX_BITS) ? MAX_BITS :
                           cfg_i.bits;                       // RULE_23
   wire  [BITS_W-1:0] nb_m1    = nb - 5'h01;
   wire               sel_rst  = sys_rst_i | ssel_n_i;       // RULE_22

   spi_slave_link u_link
   (
      .sck_i      (spi_sck_i),
      .sys_rst_i  (sys_rst_i),
      .sel_rst_i  (sel_rst),
      .cpol_i     (cfg_i.cpol),
      .cpha_i     (cfg_i.cpha),
      .bits_i     (nb),
      .tx_i       (shreg),
      .mosi_i     (mosi_i),
      .miso_o     (link_miso),
      .mid_o      (link_mid),
      .done_tgl_o (link_tgl),
      .rx_o       (link_rx)
   );

   spi_sync #(.W(SYNC_W), .INIT(5'h10)) u_sync
   (
      .clk_i (clk_i),
      .rst_i (sys_rst_i),
      .ce_i  (ce_i),
      .d_i   ({ssel_n_i, miso_i, link_mid, link_tgl, link_miso}),
      .q_o   (sync_q)
   );

   wire ssel_act  = ~sync_q[4];                              // RULE_22
   wire miso_s    = sync_q[3];
   wire mid_s     = sync_q[2];
   wire tgl_s     = sync_q[1];
   wire lmiso_s   = sync_q[0];

   // ****************************************
   // Mode and mode fault
   // ****************************************
   wire slave      = ~master_o;
   wire fault      = master_o & ssel_act;                    // RULE_16
   wire next_lock  = cfg_i.master & (fault_lock | fault);
   wire next_mst   = cfg_i.master & ~next_lock;              // RULE_16

   // ****************************************
   // Master clock divider
   // ****************************************
   wire [DIV_W-1:0]  div   = (ccr_i < MIN_DIV) ? MIN_DIV : ccr_i; // RULE_24
   wire [DIV_W-2:0]  half  = div[DIV_W-1:1];
   wire              tick  = (state == M_RUN) &&
                             (div_cnt == half - 7'h01);      // RULE_06
   wire              lead  = ~edge_cnt[0];
   wire              samp  = lead ^ cfg_i.cpha;              // RULE_20
   wire [EDGE_W-1:0] e_end = {nb, 1'b0} - 6'h01;
   wire              m_fin = tick && (edge_cnt == e_end);    // RULE_09
   wire [DATA_W-1:0] mask  = 16'hffff >> (5'h10 - nb);

   // ****************************************
   // Slave transfer tracking
   // ****************************************
   wire s_done   = slave & (tgl_s ^ tgl_prev);               // RULE_10
   wire s_start  = slave & ~slv_open &
                   (cfg_i.cpha ? (ssel_act & mid_s)          // RULE_02
                               : (ssel_act & ~ssel_prev));   // RULE_01
   wire s_abort  = slave & slv_open & ~s_done &
                   ~ssel_act & ssel_prev;                    // RULE_17

   // ****************************************
   // Data register access
   // ****************************************
   wire cmp      = m_done | s_done;
   wire busy     = (state == M_RUN) | slv_open;
   wire wr_block = wc_window | busy;                         // RULE_14
   wire wr_ok    = dat_wr_i & ~wr_block;
   wire m_start  = wr_ok & master_o & ~fault;                // RULE_08
   wire st_clr   = stat_rd_i & flags.transfer_done_flag;
   wire dat_acc  = dat_rd_i | dat_wr_i;

   // ****************************************
   // Next flags
   // ****************************************
   status_t next_flags;

   always_comb
   begin
      next_flags = flags;
      if (stat_rd_i)
      begin
         next_flags.read_overrun_flag    = 1'b0;             // RULE_25
         next_flags.write_collision_flag = 1'b0;
         next_flags.mode_fault_flag      = 1'b0;
         next_flags.slave_abort_flag     = 1'b0;
      end
      if (dat_acc && armed)
         next_flags.transfer_done_flag = 1'b0;               // RULE_11
      if (cmp && flags.transfer_done_flag)
         next_flags.read_overrun_flag = 1'b1;                // RULE_13
      if (cmp)
         next_flags.transfer_done_flag = 1'b1;               // RULE_09
      if (dat_wr_i && wr_block)
         next_flags.write_collision_flag = 1'b1;             // RULE_14
      if (fault)
         next_flags.mode_fault_flag = 1'b1;                  // RULE_16
      if (s_abort)
         next_flags.slave_abort_flag = 1'b1;                 // RULE_17
   end

   // ****************************************
   // Master sequencer
   // ****************************************
   always_comb
   begin
      next_state = state;
      case (state)
         M_IDLE:
         begin
            if (m_start)
               next_state = M_RUN;
         end
         M_RUN:
         begin
            if (m_fin || fault)
               next_state = M_IDLE;
         end
         default:
            next_state = M_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         state <= M_IDLE;
      else if (ce_i)
         state <= next_state;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         div_cnt  <= 7'h00;
         edge_cnt <= 6'h00;
         sck_o    <= 1'b0;
         m_done   <= 1'b0;
      end
      else if (ce_i)
      begin
         m_done <= m_fin & ~fault;
         if (state != M_RUN || tick)
            div_cnt <= 7'h00;
         else
            div_cnt <= div_cnt + 7'h01;
         if (state != M_RUN)
         begin
            edge_cnt <= 6'h00;
            sck_o    <= cfg_i.cpol;                          // RULE_20
         end
         else if (tick)
         begin
            edge_cnt <= edge_cnt + 6'h01;
            sck_o    <= ~sck_o;                              // RULE_24
         end
      end
   end

   // ****************************************
   // Shift register and transmit line
   // ****************************************
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         shreg  <= DATA_RST;
         mosi_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wr_ok)
         begin
            shreg <= dat_wdata_i;                            // RULE_04
            if (!cfg_i.cpha)
               mosi_o <= dat_wdata_i[nb_m1[3:0]];            // RULE_20
         end
         else if (s_abort)
            shreg <= DATA_RST;                               // RULE_17
         else if (tick && samp)
            shreg <= {shreg[DATA_W-2:0], miso_s};
         else if (tick)
            mosi_o <= shreg[nb_m1[3:0]];
      end
   end

   // ****************************************
   // Receive buffer
   // ****************************************
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rx_buf <= DATA_RST;
      else if (ce_i && cmp && !flags.transfer_done_flag)
         rx_buf <= (m_done ? shreg : link_rx) & mask;        // RULE_05
   end

   // ****************************************
   // Flags and windows
   // ****************************************
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         flags      <= STATUS_RST;
         armed      <= 1'b0;
         wc_window  <= 1'b0;
         slv_open   <= 1'b0;
         ssel_prev  <= 1'b0;
         tgl_prev   <= 1'b0;
      end
      else if (ce_i)
      begin
         flags     <= next_flags;                            // RULE_03
         ssel_prev <= ssel_act;
         tgl_prev  <= tgl_s;
         if (!next_flags.transfer_done_flag)
            armed <= 1'b0;
         else if (st_clr)
            armed <= 1'b1;                                   // RULE_11
         if (m_start || s_start)
            wc_window <= 1'b1;                               // RULE_14
         else if (st_clr || s_abort)
            wc_window <= 1'b0;
         if (s_done || s_abort || !ssel_act || master_o)
            slv_open <= 1'b0;                                // RULE_22
         else if (s_start)
            slv_open <= 1'b1;
      end
   end

   // ****************************************
   // Mode register and pin drivers
   // ****************************************
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         fault_lock <= 1'b0;
         master_o   <= 1'b0;
         sck_oe_o   <= 1'b0;
         mosi_oe_o  <= 1'b0;
         miso_oe_o  <= 1'b0;
         miso_o     <= 1'b0;
      end
      else if (ce_i)
      begin
         fault_lock <= next_lock;
         master_o   <= next_mst;                             // RULE_16
         sck_oe_o   <= next_mst;
         mosi_oe_o  <= next_mst;
         miso_oe_o  <= ~next_mst & ssel_act;                 // RULE_07
         miso_o     <= lmiso_s;
      end
   end

   // ****************************************
   // Register outputs
   // ****************************************
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rdata_o  <= DATA_RST;
         status_o <= STATUS_RST;
      end
      else if (ce_i)
      begin
         rdata_o  <= rx_buf;
         status_o <= flags;
      end
   end

endmodule : spi_ctrl
`default_nettype wire

// File: sim/spi_ctrl_monitor.sv
// Port assertions of the SPI controller
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_monitor
(
   input wire logic                        clk_i,
   input wire logic                        sys_rst_i,
   input wire spi_pkg::cfg_t               cfg_i,
   input wire logic                        dat_wr_i,
   input wire logic                        dat_rd_i,
   input wire logic                        stat_rd_i,
   input wire logic [spi_pkg::DATA_W-1:0]  rdata_o,
   input wire spi_pkg::status_t            status_o,
   input wire logic                        master_o,
   input wire logic                        sck_o,
   input wire logic                        sck_oe_o,
   input wire logic                        ssel_n_i,
   input wire logic                        mosi_oe_o,
   input wire logic                        miso_oe_o
);
   import spi_pkg::*;
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_fault_start;
      master_o && $fell(ssel_n_i);
   endsequence
   sequence s_fault_end;
      status_o.mode_fault_flag && !master_o;
   endsequence
   property p_mode_fault;
      s_fault_start |-> ##[1:8] s_fault_end;
   endproperty
   property p_fault_off;
      $rose(status_o.mode_fault_flag) |-> ##[0:4] (!sck_oe_o && !mosi_oe_o);
   endproperty
   property p_sck_rate;
      (sck_oe_o && $changed(sck_o)) |=> $stable(sck_o)[*3];
   endproperty
   property p_slave_quiet;
      ssel_n_i[*5] |-> !miso_oe_o;
   endproperty
   property p_flag_clear;
      ($fell(status_o.slave_abort_flag) || $fell(status_o.mode_fault_flag)
       || $fell(status_o.read_overrun_flag)
       || $fell(status_o.write_collision_flag)) |-> $past(stat_rd_i, 2);
   endproperty
   property p_done_clear;
      $fell(status_o.transfer_done_flag)
         |-> ($past(dat_rd_i, 2) || $past(dat_wr_i, 2));
   endproperty
   property p_collision;
      $rose(status_o.write_collision_flag) |-> $past(dat_wr_i, 2);
   endproperty
   property p_overrun;
      $rose(status_o.read_overrun_flag)
         |-> (status_o.transfer_done_flag && $stable(rdata_o));
   endproperty
   property p_idle_sck;
      (master_o && $rose(status_o.transfer_done_flag)) |-> sck_o == cfg_i.cpol;
   endproperty
   a_mode_fault: assert property (p_mode_fault)
      else $error("mode fault not taken");
   a_fault_off: assert property (p_fault_off)
      else $error("drivers still on after mode fault");
   a_sck_rate: assert property (p_sck_rate)
      else $error("clock half period too short");
   a_slave_quiet: assert property (p_slave_quiet)
      else $error("data out driven while deselected");
   a_flag_clear: assert property (p_flag_clear)
      else $error("exception flag cleared without status read");
   a_done_clear: assert property (p_done_clear)
      else $error("done cleared without data access");
   a_collision: assert property (p_collision)
      else $error("collision without data write");
   a_overrun: assert property (p_overrun)
      else $error("overrun changed the buffer");
   a_idle_sck: assert property (p_idle_sck)
      else $error("done before clock returned idle");
endmodule : spi_ctrl_monitor
bind spi_ctrl spi_ctrl_monitor mon (.clk_i, .sys_rst_i, .cfg_i, .dat_wr_i,
   .dat_rd_i, .stat_rd_i, .rdata_o, .status_o, .master_o, .sck_o,
   .sck_oe_o, .ssel_n_i, .mosi_oe_o, .miso_oe_o);
`default_nettype wire

// File: sim/spi_peer.sv
// Far-side SPI device: slave to our master, master to our slave
`timescale 1ns/1ps
`default_nettype none
module spi_peer
(
   input  wire logic       cpol_i,
   input  wire logic       cpha_i,
   input  wire logic [4:0] bits_i,
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            sck_o,
   output logic            ssel_n_o,
   output logic            mosi_o
);
   // ****
   // Slave role
   // ****
   localparam int HALF = 24;
   logic        arm = 1'b0;
   logic        lead;
   logic [15:0] stx;
   logic [15:0] srx;
   wire         edge_s = sck_i ^ cpol_i ^ cpha_i;
   initial
   begin
      sck_o = 1'b0;
      ssel_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   always @(posedge edge_s) if (arm) srx = {srx[14:0], mosi_i};
   always @(negedge edge_s) if (arm) if (lead) lead = 1'b0; else stx <<= 1;
   assign miso_o = arm ? stx[bits_i-1] : ~stx[bits_i-1];
   task slave_arm(input logic [15:0] tx);
      stx = tx;
      srx = '0;
      lead = cpha_i;
      arm = 1'b1;
   endtask : slave_arm
   task slave_disarm(output logic [15:0] rx);
      arm = 1'b0;
      rx = srx;
   endtask : slave_disarm
   // ****
   // Master role, cut below n aborts the word
   // ****
   task automatic xfer(input logic [15:0] tx, input int n, input int cut,
                       output logic [15:0] rx);
      rx = '0;
      sck_o = cpol_i;
      #HALF;
      ssel_n_o = 1'b0;
      mosi_o = tx[n-1];
      #(2*HALF);
      for (int i = 0; i < cut; i++)
      begin
         sck_o = ~sck_o;
         if (cpha_i) mosi_o = tx[n-1-i];
         else rx = {rx[14:0], miso_i};
         #HALF;
         sck_o = ~sck_o;
         if (cpha_i) rx = {rx[14:0], miso_i};
         else if (i < n-1) mosi_o = tx[n-2-i];
         #HALF;
      end
      ssel_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #(2*HALF);
   endtask : xfer
endmodule : spi_peer
`default_nettype wire

// File: sim/test_spi_master_slave_controller.sv
// Self-checking bench of the SPI master/slave controller
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_controller;
   import spi_pkg::*;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        dat_wr_i = 1'b0;
   logic        dat_rd_i = 1'b0;
   logic        ce = 1'b1;
   logic        stat_rd_i = 1'b0;
   cfg_t        cfg = '0;
   logic [7:0]  ccr = 8'h08;
   logic [15:0] wdata = '0;
   logic [15:0] rdata;
   status_t     status;
   status_t     es = '0;
   logic        master, sck, sck_oe, mosi, mosi_oe, miso, miso_oe;
   logic        p_sck, p_ssel_n, p_mosi, p_miso;
   logic [31:0] seed = 32'h00000061;
   logic [15:0] tx, px, got, mask, last;
   int          n, miscompares = 0, cmp_count = 0;
   always #2.5 clk_i = ~clk_i;
   spi_ctrl uut (.clk_i, .sys_rst_i, .ce_i(ce), .cfg_i(cfg), .ccr_i(ccr),
      .dat_wr_i, .dat_wdata_i(wdata), .dat_rd_i, .stat_rd_i,
      .rdata_o(rdata), .status_o(status), .master_o(master),
      .spi_sck_i(p_sck), .sck_o(sck), .sck_oe_o(sck_oe),
      .ssel_n_i(p_ssel_n), .mosi_i(p_mosi), .mosi_o(mosi),
      .mosi_oe_o(mosi_oe), .miso_i(p_miso), .miso_o(miso),
      .miso_oe_o(miso_oe));
   spi_peer peer (.cpol_i(cfg.cpol), .cpha_i(cfg.cpha), .bits_i(cfg.bits),
      .sck_i(sck_oe ? sck : 1'bz), .mosi_i(mosi_oe ? mosi : 1'bz),
      .miso_i(miso_oe ? miso : 1'bz), .miso_o(p_miso), .sck_o(p_sck),
      .ssel_n_o(p_ssel_n), .mosi_o(p_mosi));
   // ****
   // Helpers
   // ****
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task poke(input int k, input logic [15:0] d);
      @(negedge clk_i);
      wdata = d;
      dat_wr_i = (k == 0);
      stat_rd_i = (k == 1);
      dat_rd_i = (k == 2);
      @(negedge clk_i);
      {dat_wr_i, stat_rd_i, dat_rd_i} = '0;
      repeat (2) @(negedge clk_i);
   endtask : poke
   task setup(input logic m, input int md);
      n = (md == 0) ? 8 : (md == 3) ? 16 : 8 + rnd() % 9;
      mask = 16'hffff >> (16 - n);
      cfg = '{m, md[1], md[0], n[4:0]};
      tx = rnd() & mask;
      px = rnd() & mask;
      repeat (6) @(negedge clk_i);
   endtask : setup
   task end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial
   begin
      #200000;
      miscompares++;
      end_of_test();
   end
   // ****
   // Tests
   // ****
   initial
   begin
      repeat (10) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      for (int md = 0; md < 4; md++)
      begin
         ccr = (md == 1) ? 8'h03 : 8'h0a;
         setup(1'b1, md);
         peer.slave_arm(px);
         poke(0, tx);
         poke(0, ~tx);
         for (int i = 0; i < 2000 && status.transfer_done_flag !== 1'b1; i++)
            @(negedge clk_i);
         peer.slave_disarm(got);
         chk(got & mask, tx);
         chk(rdata & mask, px);
         es = 5'h03;
         chk(status, es);
         poke(1, 0);
         poke(2, 0);
         es = '0;
         chk(status, es);
         $display("master test %0d done", md);
      end
      for (int md = 0; md < 4; md++)
      begin
         setup(1'b0, md);
         poke(0, tx);
         peer.xfer(px, n, n, got);
         chk(got & mask, tx);
         chk(rdata & mask, px);
         es = 5'h01;
         chk(status, es);
         last = rdata;
         if (md == 3)
         begin
            peer.xfer(~px, n, n, got);
            chk(rdata, last);
            es.read_overrun_flag = 1'b1;
            chk(status, es);
         end
         poke(1, 0);
         poke(2, 0);
         es = '0;
         chk(status, es);
         $display("slave test %0d done", md);
      end
      setup(1'b0, 0);
      poke(0, tx);
      peer.xfer(px, n, 3, got);
      es.slave_abort_flag = 1'b1;
      chk(status, es);
      chk(rdata, last);
      poke(1, 0);
      es = '0;
      chk(status, es);
      peer.xfer(px, n, n, got);
      chk(got & mask, 16'h0000);
      chk(rdata & mask, px);
      poke(1, 0);
      poke(2, 0);
      $display("abort test done");
      setup(1'b1, 0);
      peer.xfer(0, 8, 0, got);
      chk(master, 1'b0);
      chk(sck_oe, 1'b0);
      es.mode_fault_flag = 1'b1;
      chk(status, es);
      ce = 1'b0;
      poke(1, 0);
      ce = 1'b1;
      chk(status, es);
      poke(1, 0);
      es = '0;
      chk(status, es);
      $display("mode fault test done");
      end_of_test();
   end
endmodule : test_spi_master_slave_controller
`default_nettype wire
